// File: verilog/mmd_pkg.sv
// Purpose: constants, types and address layout of the memory map decoder
// Assumes: single clock, synchronous active-low reset
// Notes:   register offsets are word indices on the plain register port
//
// Operation
// - every reset restarts fetch at address 0000H
// - interrupt vectors at 0003H, eight bytes apart
// - size field splits flash into boot/application
// - boot mode relocates address 0000H to boot start
// - code move reads application flash region
// - above 7FH: direct->SFR, indirect->upper RAM
// - SFR bit access only at x0H/x8H
// - low 32 bytes: four banks of eight
// - bytes 20H-2FH hold bit addresses 00H-7FH
// - lower 128 bytes: direct or indirect
// - stack pointer resets to 07H
// - push: increment pointer, then write
// - pop: read first, then decrement pointer
// - return addresses stacked anywhere in internal RAM
// - 768-byte auxiliary RAM at 000H-2FFH
// - stack never touches auxiliary RAM
// - flash blocks built from whole 128-byte pages
package mmd_pkg;

   // ==========================================================
   // program memory
   localparam logic [15:0] RESET_PC    = 16'h0000;
   localparam logic [15:0] VEC_BASE    = 16'h0003;
   localparam int          VEC_SHIFT   = 3;
   localparam int          FADDR_W     = 15;
   localparam int          PAGE_SHIFT  = 7;
   localparam logic [7:0]  KB_PAGES    = 8'h08;
   localparam logic [FADDR_W-1:0] FLASH_BYTES = 15'h4800;
   localparam logic [7:0]  CFG_RESET   = 8'hFF;
   localparam logic [2:0]  SIZE_NONE   = 3'b111;
   localparam logic [2:0]  SIZE_1K     = 3'b110;
   localparam logic [2:0]  SIZE_2K     = 3'b101;
   localparam logic [2:0]  SIZE_3K     = 3'b100;

   // ==========================================================
   // internal data memory
   localparam logic [7:0]  DIRECT_TOP  = 8'h7F;
   localparam logic [7:0]  BIT_BASE    = 8'h20;
   localparam logic [7:0]  SP_RESET    = 8'h07;
   localparam logic [7:0]  SFR_SP_ADDR = 8'h81;
   localparam int          BANK_LSB    = 3;

   // ==========================================================
   // auxiliary RAM
   localparam int          AUXILIARY_RAM_BYTES  = 768;
   localparam logic [15:0] AUXILIARY_RAM_TOP    = 16'h02FF;

   // ==========================================================
   // register port
   localparam logic [1:0]  REG_CFG     = 2'h0;
   localparam logic [1:0]  REG_SP      = 2'h1;
   localparam logic [1:0]  REG_STATUS  = 2'h2;

   typedef enum logic [2:0] {
      DM_DIRECT, DM_INDIRECT, DM_REG, DM_BIT, DM_PUSH, DM_POP
   } mmd_dm_op_t;

   typedef enum logic [1:0] {TGT_IRAM, TGT_SFR, TGT_SP} mmd_tgt_t;

   typedef struct packed {
      mmd_dm_op_t op;
      logic [7:0] addr;
      logic       wr;
      logic [7:0] wdata;
   } mmd_dm_req_t;

   typedef struct packed {
      logic       req;
      logic [7:0] addr;
      logic       wr;
      logic [7:0] wdata;
      logic       bit_en;
      logic [2:0] bit_idx;
   } mmd_sfr_req_t;

endpackage

// File: verilog/mmd_memory_map_decoder.sv
// Purpose: program, data and auxiliary memory decoding for the CPU core
// Assumes: CPU requests are on i_clk_sys; config byte is static flash data
// Notes:   data reads answer two cycles after the request
//
// Implementation choices: the placing of the registers and the strobed register port.
module mmd_memory_map_decoder
   import mmd_pkg::*;
(
   input  wire logic               i_clk_sys,
   input  wire logic               i_nrst,
   // register port
   input  wire logic [1:0]         i_reg_addr,
   input  wire logic [7:0]         i_reg_wdata,
   input  wire logic               i_reg_wr,
   input  wire logic               i_reg_rd,
   output logic [7:0]              o_reg_rdata,
   // reset-time configuration
   input  wire logic [7:0]         i_cfg_byte,
   input  wire logic               i_boot_sel,
   output logic [7:0]              o_cfg_pending,
   // program memory
   input  wire logic               i_fetch_req,
   input  wire logic               i_code_move,
   input  wire logic [15:0]        i_pc,
   output logic                    o_flash_rd,
   output logic [FADDR_W-1:0]      o_flash_addr,
   output logic                    o_fetch_fault,
   input  wire logic               i_vec_req,
   input  wire logic [4:0]         i_vec_num,
   output logic [15:0]             o_vec_pc,
   // internal data memory
   input  wire logic               i_dm_req,
   input  wire mmd_dm_req_t        i_dm,
   input  wire logic [7:0]         i_program_status_word,
   output logic [7:0]              o_dm_rdata,
   output logic                    o_dm_rvalid,
   output logic [7:0]              o_stack_pointer,
   output mmd_sfr_req_t            o_sfr,
   input  wire logic [7:0]         i_sfr_rdata,
   // auxiliary RAM
   input  wire logic               i_xm_req,
   input  wire logic               i_xm_wr,
   input  wire logic [15:0]        i_xm_addr,
   input  wire logic [7:0]         i_xm_wdata,
   output logic [7:0]              o_xm_rdata,
   output logic                    o_xm_rvalid,
   output logic                    o_xm_err
);

   // ==========================================================
   // functions
   function automatic logic [7:0] mmd_boot_pages(input logic [2:0] sz);
      logic [7:0] pg;
      pg = 8'h00;
      case (sz)
         SIZE_NONE: pg = 8'h00;
         SIZE_1K:   pg = KB_PAGES;
         SIZE_2K:   pg = 8'(KB_PAGES * 2);
         SIZE_3K:   pg = 8'(KB_PAGES * 3);
         default:   pg = 8'(KB_PAGES * 4);
      endcase
      return pg;
   endfunction

   // ==========================================================
   // reset-time capture of size field and boot selection
   logic [2:0]  size_r;
   logic        boot_mode_r;
   logic        cap_done_r;
   logic [7:0]  cfg_pend_r;

   // flip-flops take constants under reset; the config byte is caught
   // on the first edge after release
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         size_r      <= SIZE_NONE;
         boot_mode_r <= 1'b0;
         cap_done_r  <= 1'b0;
      end else if (!cap_done_r) begin
         size_r      <= i_cfg_byte[2:0];
         boot_mode_r <= i_boot_sel && (i_cfg_byte[2:0] != SIZE_NONE);
         cap_done_r  <= 1'b1;
      end
   end

   // software writes here only change o_cfg_pending; reset reloads it to CFG_RESET
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         cfg_pend_r <= CFG_RESET;
      end else if (i_reg_wr && i_reg_addr == REG_CFG) begin
         cfg_pend_r <= i_reg_wdata;
      end
   end
   assign o_cfg_pending = cfg_pend_r;

   // ==========================================================
   // program flash partition
   logic [7:0]         boot_pg;
   logic [FADDR_W-1:0] boot_bytes;
   logic [FADDR_W-1:0] app_bytes;
   logic [FADDR_W-1:0] boot_start;
   logic               in_app;
   logic               in_boot;

   assign boot_pg    = mmd_boot_pages(size_r);
   assign boot_bytes = FADDR_W'({boot_pg, {PAGE_SHIFT{1'b0}}});
   assign app_bytes  = FLASH_BYTES - boot_bytes;
   // boot block sits above the application block
   assign boot_start = app_bytes;
   assign in_app     = i_pc < {1'b0, app_bytes};
   assign in_boot    = i_pc < {1'b0, boot_bytes};

   logic               flash_rd_r;
   logic [FADDR_W-1:0] flash_addr_r;
   logic               fault_r;

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         flash_rd_r   <= 1'b0;
         flash_addr_r <= '0;
         fault_r      <= 1'b0;
      end else if (i_fetch_req) begin
         if (i_code_move) begin
            // data reads always see the application block
            flash_rd_r   <= in_app;
            flash_addr_r <= in_app ? i_pc[FADDR_W-1:0] : '0;
            fault_r      <= !in_app;
         end else if (boot_mode_r) begin
            flash_rd_r   <= in_boot;
            flash_addr_r <= in_boot ? boot_start + i_pc[FADDR_W-1:0] : '0;
            fault_r      <= !in_boot;
         end else begin
            flash_rd_r   <= in_app;
            flash_addr_r <= in_app ? i_pc[FADDR_W-1:0] : '0;
            fault_r      <= !in_app;
         end
      end else begin
         flash_rd_r <= 1'b0;
         fault_r    <= 1'b0;
      end
   end
   assign o_flash_rd    = flash_rd_r;
   assign o_flash_addr  = flash_addr_r;
   assign o_fetch_fault = fault_r;

   // ==========================================================
   // restart and interrupt vectors
   logic [15:0] vec_pc_r;

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         vec_pc_r <= RESET_PC;
      end else if (i_vec_req) begin
         vec_pc_r <= VEC_BASE + (16'(i_vec_num) << VEC_SHIFT);
      end
   end
   assign o_vec_pc = vec_pc_r;

   // ==========================================================
   // internal data memory decode
   logic [7:0] iram [0:255];
   logic [7:0] sp_r;
   logic [1:0] bank;
   mmd_tgt_t   tgt;
   logic [7:0] d_addr;
   logic       d_bit;
   logic       d_wr;

   assign bank = i_program_status_word[BANK_LSB+1:BANK_LSB];

   always_comb begin
      tgt    = TGT_IRAM;
      d_addr = i_dm.addr;
      d_bit  = 1'b0;
      d_wr   = i_dm.wr;
      case (i_dm.op)
         DM_DIRECT: begin
            if (i_dm.addr == SFR_SP_ADDR) begin
               tgt = TGT_SP;
            end else if (i_dm.addr > DIRECT_TOP) begin
               tgt = TGT_SFR;
            end
         end
         DM_INDIRECT: tgt = TGT_IRAM;
         DM_REG: d_addr = {3'b000, bank, i_dm.addr[2:0]};
         DM_BIT: begin
            d_bit = 1'b1;
            if (i_dm.addr[7]) begin
               tgt    = TGT_SFR;
               d_addr = {i_dm.addr[7:3], 3'b000};
            end else begin
               d_addr = BIT_BASE + {4'h0, i_dm.addr[6:3]};
            end
         end
         DM_PUSH: begin
            d_addr = sp_r + 8'h01;
            d_wr   = 1'b1;
         end
         DM_POP: begin
            d_addr = sp_r;
            d_wr   = 1'b0;
         end
         default: tgt = TGT_IRAM;
      endcase
   end

   // register port write wins over a CPU stack update in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         sp_r <= SP_RESET;
      end else if (i_reg_wr && i_reg_addr == REG_SP) begin
         sp_r <= i_reg_wdata;
      end else if (i_dm_req) begin
         if (tgt == TGT_SP && d_wr) begin
            sp_r <= i_dm.wdata;
         end else if (i_dm.op == DM_PUSH) begin
            sp_r <= sp_r + 8'h01;
         end else if (i_dm.op == DM_POP) begin
            sp_r <= sp_r - 8'h01;
         end
      end
   end
   assign o_stack_pointer = sp_r;

   // ==========================================================
   // access stage
   logic       s1_vld_r;
   mmd_tgt_t   s1_tgt_r;
   logic [7:0] s1_addr_r;
   logic       s1_wr_r;
   logic [7:0] s1_wdata_r;
   logic       s1_bit_r;
   logic [2:0] s1_bidx_r;

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         s1_vld_r   <= 1'b0;
         s1_tgt_r   <= TGT_IRAM;
         s1_addr_r  <= 8'h00;
         s1_wr_r    <= 1'b0;
         s1_wdata_r <= 8'h00;
         s1_bit_r   <= 1'b0;
         s1_bidx_r  <= 3'h0;
      end else begin
         s1_vld_r   <= i_dm_req;
         s1_tgt_r   <= tgt;
         s1_addr_r  <= d_addr;
         s1_wr_r    <= d_wr;
         s1_wdata_r <= i_dm.wdata;
         s1_bit_r   <= d_bit;
         s1_bidx_r  <= i_dm.addr[2:0];
      end
   end

   // internal RAM writes happen here, in the access stage, so back-to-back stack ops stay ordered
   always_ff @(posedge i_clk_sys) begin
      if (s1_vld_r && s1_wr_r && s1_tgt_r == TGT_IRAM) begin
         if (s1_bit_r) begin
            iram[s1_addr_r][s1_bidx_r] <= s1_wdata_r[0];
         end else begin
            iram[s1_addr_r] <= s1_wdata_r;
         end
      end
   end

   assign o_sfr.req     = s1_vld_r && s1_tgt_r == TGT_SFR;
   assign o_sfr.addr    = s1_addr_r;
   assign o_sfr.wr      = s1_wr_r;
   assign o_sfr.wdata   = s1_wdata_r;
   assign o_sfr.bit_en  = s1_bit_r;
   assign o_sfr.bit_idx = s1_bidx_r;

   logic [7:0] rd_byte;
   always_comb begin
      case (s1_tgt_r)
         TGT_SFR: rd_byte = i_sfr_rdata;
         TGT_SP:  rd_byte = sp_r;
         default: rd_byte = iram[s1_addr_r];
      endcase
   end

   logic [7:0] dm_rdata_r;
   logic       dm_rvalid_r;

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         dm_rdata_r  <= 8'h00;
         dm_rvalid_r <= 1'b0;
      end else begin
         dm_rvalid_r <= s1_vld_r && !s1_wr_r;
         if (s1_vld_r && !s1_wr_r) begin
            dm_rdata_r <= s1_bit_r ? {7'h00, rd_byte[s1_bidx_r]} : rd_byte;
         end
      end
   end
   assign o_dm_rdata  = dm_rdata_r;
   assign o_dm_rvalid = dm_rvalid_r;

   // ==========================================================
   // auxiliary RAM, reachable only by the external move path
   logic [7:0] auxiliary_ram [0:AUXILIARY_RAM_BYTES-1];
   logic       xm_ok;
   logic [7:0] xm_rdata_r;
   logic       xm_rvalid_r;
   logic       xm_err_r;

   assign xm_ok = i_xm_addr <= AUXILIARY_RAM_TOP;

   always_ff @(posedge i_clk_sys) begin
      if (i_xm_req && i_xm_wr && xm_ok) begin
         auxiliary_ram[i_xm_addr[9:0]] <= i_xm_wdata;
      end
   end

   // out-of-range accesses read zero and drop writes
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         xm_rdata_r  <= 8'h00;
         xm_rvalid_r <= 1'b0;
         xm_err_r    <= 1'b0;
      end else begin
         xm_rvalid_r <= i_xm_req && !i_xm_wr;
         xm_err_r    <= i_xm_req && !xm_ok;
         if (i_xm_req && !i_xm_wr) begin
            xm_rdata_r <= xm_ok ? auxiliary_ram[i_xm_addr[9:0]] : 8'h00;
         end
      end
   end
   assign o_xm_rdata  = xm_rdata_r;
   assign o_xm_rvalid = xm_rvalid_r;
   assign o_xm_err    = xm_err_r;

   // ==========================================================
   // register port read
   logic [7:0] reg_rdata_r;

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         reg_rdata_r <= 8'h00;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            REG_CFG:    reg_rdata_r <= cfg_pend_r;
            REG_SP:     reg_rdata_r <= sp_r;
            REG_STATUS: reg_rdata_r <= {3'h0, cap_done_r, boot_mode_r, size_r};
            default:    reg_rdata_r <= 8'h00;
         endcase
      end else begin
         reg_rdata_r <= 8'h00;
      end
   end
   assign o_reg_rdata = reg_rdata_r;

endmodule

// File: tb/mmd_sfr_model.sv
// Purpose: special-function-register side answering the decoder's requests
// Assumes: the answer is combinational in the request cycle
// Notes:   idle data change every cycle, so a stale sample never matches
module mmd_sfr_model
   import mmd_pkg::*;
(
   input  wire logic         i_clk_sys,
   input  wire mmd_sfr_req_t i_sfr,
   output logic [7:0]        o_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] idle_r = 8'h00;
   always @(posedge i_clk_sys) begin
      idle_r <= idle_r + 8'h01;
   end
   // direct accesses above 7FH other than 81H, and bit accesses at 80H and above, land here only
   assign o_rdata = i_sfr.req ? (i_sfr.addr ^ 8'hA5) : idle_r;
endmodule

// File: tb/mmd_memory_map_decoder_chk.sv
// Purpose: port-level timing and decoding checks of the memory map decoder
// Assumes: one clock, synchronous active-low reset
// Notes:   attached by the bind at the foot of this file
module mmd_chk
   import mmd_pkg::*;
(
   input wire logic               i_clk_sys,
   input wire logic               i_nrst,
   input wire logic [1:0]         i_reg_addr,
   input wire logic               i_reg_wr,
   input wire logic               i_fetch_req,
   input wire logic               i_code_move,
   input wire logic [15:0]        i_pc,
   input wire logic               o_flash_rd,
   input wire logic [FADDR_W-1:0] o_flash_addr,
   input wire logic               i_vec_req,
   input wire logic [4:0]         i_vec_num,
   input wire logic [15:0]        o_vec_pc,
   input wire logic               i_dm_req,
   input wire mmd_dm_req_t        i_dm,
   input wire logic               o_dm_rvalid,
   input wire logic [7:0]         o_stack_pointer,
   input wire mmd_sfr_req_t       o_sfr,
   input wire logic               i_xm_req,
   input wire logic               i_xm_wr,
   input wire logic [15:0]        i_xm_addr,
   input wire logic               o_xm_rvalid,
   input wire logic               o_xm_err
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // ==========================================================
   // stack steps; a port write to the pointer wins, so it is excluded
   sequence s_push;
      i_dm_req && i_dm.op == DM_PUSH && !(i_reg_wr && i_reg_addr == REG_SP);
   endsequence
   sequence s_pop;
      i_dm_req && i_dm.op == DM_POP && !(i_reg_wr && i_reg_addr == REG_SP);
   endsequence
   // ==========================================================
   // assertions
   chk_sp_reset: assert property (disable iff (1'b0)
      !i_nrst |=> o_stack_pointer == SP_RESET) else $error("stack pointer not reloaded");
   chk_push_inc: assert property (
      s_push |=> o_stack_pointer == $past(o_stack_pointer) + 8'h01)
      else $error("push did not raise the stack pointer");
   chk_pop_dec: assert property (
      s_pop |=> o_stack_pointer == $past(o_stack_pointer) - 8'h01 ##1 o_dm_rvalid)
      else $error("pop did not lower the pointer and answer");
   chk_sfr_direct: assert property (
      i_dm_req && i_dm.op == DM_DIRECT && i_dm.addr > DIRECT_TOP && i_dm.addr != SFR_SP_ADDR
      |=> o_sfr.req && o_sfr.addr == $past(i_dm.addr)) else $error("direct high not sent out");
   chk_iram_indirect: assert property (
      i_dm_req && i_dm.op == DM_INDIRECT && !i_dm.wr |=> !o_sfr.req ##1 o_dm_rvalid)
      else $error("indirect read left internal ram");
   chk_sfr_bit: assert property (
      i_dm_req && i_dm.op == DM_BIT && i_dm.addr[7]
      |=> o_sfr.req && o_sfr.bit_en && o_sfr.addr == ($past(i_dm.addr) & 8'hF8))
      else $error("bit access hit a wrong register byte");
   chk_code_move: assert property (
      i_fetch_req && i_code_move && i_pc < 16'h3800
      |=> o_flash_rd && {1'b0, o_flash_addr} == $past(i_pc)) else $error("code move misplaced");
   chk_vec_addr: assert property (
      i_vec_req |=> o_vec_pc == VEC_BASE + {8'h00, $past(i_vec_num), 3'b000})
      else $error("vector address wrong");
   chk_auxiliary_ram_err: assert property (
      // out-of-range reads still answer, with zero data and the error flag
      i_xm_req && i_xm_addr > AUXILIARY_RAM_TOP |=> o_xm_err && o_xm_rvalid == !$past(i_xm_wr))
      else $error("aux access above range not refused");
   chk_auxiliary_ram_read: assert property (
      i_xm_req && !i_xm_wr && i_xm_addr <= AUXILIARY_RAM_TOP |=> o_xm_rvalid && !o_xm_err)
      else $error("aux read in range not answered");
endmodule
bind mmd_memory_map_decoder mmd_chk u_chk (
   .i_clk_sys, .i_nrst, .i_reg_addr, .i_reg_wr, .i_fetch_req, .i_code_move, .i_pc,
   .o_flash_rd, .o_flash_addr, .i_vec_req, .i_vec_num, .o_vec_pc, .i_dm_req, .i_dm,
   .o_dm_rvalid, .o_stack_pointer, .o_sfr, .i_xm_req, .i_xm_wr, .i_xm_addr,
   .o_xm_rvalid, .o_xm_err
);

// File: tb/mmd_memory_map_decoder_bench.sv
// Purpose: directed test of the memory map decoder
// Assumes: the sfr model answers address xor A5H
// Notes:   size codes 111 down to 010 are each visited through a fresh reset, with both boot selections
module mmd_memory_map_decoder_bench
   import mmd_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic         i_clk_sys = 1'b0, i_nrst = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic         i_boot_sel = 1'b0, i_fetch_req = 1'b0, i_code_move = 1'b0;
   logic         i_vec_req = 1'b0, i_dm_req = 1'b0, i_xm_req = 1'b0, i_xm_wr = 1'b0;
   logic [1:0]   i_reg_addr = 2'h0;
   logic [4:0]   i_vec_num = 5'h00;
   logic [7:0]   i_reg_wdata = 8'h00, i_cfg_byte = 8'hFF, i_xm_wdata = 8'h00;
   logic [7:0]   i_program_status_word = 8'h00;
   logic [15:0]  i_pc = 16'h0000, i_xm_addr = 16'h0000;
   mmd_dm_req_t  i_dm = '0;
   logic [7:0]   o_reg_rdata, o_cfg_pending, o_dm_rdata, o_stack_pointer, o_xm_rdata;
   logic [7:0]   i_sfr_rdata;
   logic         o_flash_rd, o_fetch_fault, o_dm_rvalid, o_xm_rvalid, o_xm_err;
   logic [14:0]  o_flash_addr;
   logic [15:0]  o_vec_pc;
   mmd_sfr_req_t o_sfr;
   int           n_mismatch = 0;
   int           n_tests = 0;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
   always #10 i_clk_sys = ~i_clk_sys;
   mmd_memory_map_decoder dut (
      .i_clk_sys, .i_nrst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
      .i_cfg_byte, .i_boot_sel, .o_cfg_pending, .i_fetch_req, .i_code_move, .i_pc,
      .o_flash_rd, .o_flash_addr, .o_fetch_fault, .i_vec_req, .i_vec_num, .o_vec_pc,
      .i_dm_req, .i_dm, .i_program_status_word, .o_dm_rdata, .o_dm_rvalid,
      .o_stack_pointer, .o_sfr, .i_sfr_rdata, .i_xm_req, .i_xm_wr, .i_xm_addr,
      .i_xm_wdata, .o_xm_rdata, .o_xm_rvalid, .o_xm_err
   );
   mmd_sfr_model u_sfr (.i_clk_sys, .i_sfr(o_sfr), .o_rdata(i_sfr_rdata));
   // ==========================================================
   // access tasks
   task automatic reg_op(input logic w, input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= w;
      i_reg_rd <= !w;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
      #1 if (!w) `CHK(o_reg_rdata, d)
   endtask
   task automatic fetch(input logic cm, input logic [15:0] pc, input logic f,
                        input logic [14:0] e);
      @(posedge i_clk_sys);
      i_fetch_req <= 1'b1;
      i_code_move <= cm;
      i_pc <= pc;
      @(posedge i_clk_sys);
      i_fetch_req <= 1'b0;
      #1 `CHK(o_fetch_fault, f)
      `CHK(o_flash_rd, !f)
      if (!f) `CHK(o_flash_addr, e)
   endtask
   // for reads d is the expected answer
   task automatic dm(input mmd_dm_op_t op, input logic [7:0] a, input logic w,
                     input logic [7:0] d);
      @(posedge i_clk_sys);
      i_dm_req <= 1'b1;
      i_dm <= '{op, a, w, d};
      @(posedge i_clk_sys);
      i_dm_req <= 1'b0;
      if (!w) begin
         @(posedge i_clk_sys);
         #1 `CHK(o_dm_rvalid, 1'b1)
         `CHK(o_dm_rdata, d)
      end
   endtask
   task automatic xm(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic er);
      @(posedge i_clk_sys);
      i_xm_req <= 1'b1;
      i_xm_wr <= w;
      i_xm_addr <= a;
      i_xm_wdata <= d;
      @(posedge i_clk_sys);
      i_xm_req <= 1'b0;
      #1 `CHK(o_xm_err, er)
      `CHK(o_xm_rvalid, !w)
      if (!w) `CHK(o_xm_rdata, d)
   endtask
   task automatic restart(input logic [2:0] sz, input logic bs);
      @(posedge i_clk_sys);
      i_cfg_byte <= {5'h1F, sz};
      i_boot_sel <= bs;
      i_nrst <= 1'b0;
      repeat (6) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      tally_and_finish();
   end
   // ==========================================================
   // sequence of tests
   initial begin
      logic [2:0]  sz;
      logic        bt;
      logic [15:0] kb, app, base, lim;
      for (int i = 0; i < 12; i++) begin
         sz = 3'(7 - i / 2);
         restart(sz, i[0]);
         kb = (sz == SIZE_NONE) ? 16'h0000 : sz[2] ? 16'(7 - sz) : 16'h0004;
         app = 16'h4800 - (kb << 10);
         bt = i[0] && (sz != SIZE_NONE);
         base = bt ? app : 16'h0000;
         lim = bt ? (kb << 10) : app;
         reg_op(1'b0, REG_STATUS, {4'h1, bt, sz});
         fetch(1'b0, 16'h0000, 1'b0, base[14:0]);
         fetch(1'b0, 16'h000B, 1'b0, 15'(base + 16'h000B));
         fetch(1'b0, lim - 16'h0001, 1'b0, 15'(base + lim - 16'h0001));
         fetch(1'b0, lim, 1'b1, 15'h0000);
         fetch(1'b1, app - 16'h0001, 1'b0, 15'(app - 16'h0001));
         fetch(1'b1, app, 1'b1, 15'h0000);
      end
      @(posedge i_clk_sys);
      i_cfg_byte <= 8'hFF;
      reg_op(1'b1, REG_CFG, 8'hFE);
      reg_op(1'b1, REG_STATUS, 8'h00);
      fetch(1'b0, 16'h0000, 1'b0, 15'h3800);
      reg_op(1'b0, REG_STATUS, 8'h1A);
      reg_op(1'b0, REG_CFG, 8'hFE);
      `CHK(o_cfg_pending, 8'hFE)
      for (int n = 0; n < 5; n++) begin
         @(posedge i_clk_sys);
         i_vec_req <= 1'b1;
         i_vec_num <= 5'(n);
         @(posedge i_clk_sys);
         i_vec_req <= 1'b0;
         #1 `CHK(o_vec_pc, 16'(16'h0003 + 8 * n))
      end
      @(posedge i_clk_sys);
      i_program_status_word <= 8'h10;
      dm(DM_DIRECT, 8'h30, 1'b1, 8'h5A);
      dm(DM_INDIRECT, 8'h30, 1'b0, 8'h5A);
      dm(DM_INDIRECT, 8'h90, 1'b1, 8'hC3);
      dm(DM_INDIRECT, 8'h90, 1'b0, 8'hC3);
      dm(DM_DIRECT, 8'h90, 1'b0, 8'h35);
      dm(DM_REG, 8'h03, 1'b1, 8'h77);
      dm(DM_INDIRECT, 8'h13, 1'b0, 8'h77);
      dm(DM_DIRECT, 8'h21, 1'b1, 8'h00);
      dm(DM_BIT, 8'h0B, 1'b1, 8'h01);
      dm(DM_DIRECT, 8'h21, 1'b0, 8'h08);
      dm(DM_BIT, 8'h0B, 1'b0, 8'h01);
      dm(DM_BIT, 8'h8B, 1'b1, 8'h01);
      // model answers 88H^A5H=2DH and 90H^A5H=35H: bit 3 is 1, then 0
      dm(DM_BIT, 8'h8B, 1'b0, 8'h01);
      dm(DM_BIT, 8'h93, 1'b0, 8'h00);
      dm(DM_DIRECT, SFR_SP_ADDR, 1'b1, 8'h40);
      dm(DM_PUSH, 8'h00, 1'b1, 8'hAB);
      dm(DM_PUSH, 8'h00, 1'b1, 8'hCD);
      reg_op(1'b0, REG_SP, 8'h42);
      dm(DM_INDIRECT, 8'h41, 1'b0, 8'hAB);
      dm(DM_POP, 8'h00, 1'b0, 8'hCD);
      dm(DM_POP, 8'h00, 1'b0, 8'hAB);
      dm(DM_DIRECT, SFR_SP_ADDR, 1'b0, 8'h40);
      xm(1'b1, 16'h0000, 8'h99, 1'b0);
      reg_op(1'b1, REG_SP, 8'hFF);
      dm(DM_PUSH, 8'h00, 1'b1, 8'h11);
      dm(DM_INDIRECT, 8'h00, 1'b0, 8'h11);
      xm(1'b0, 16'h0000, 8'h99, 1'b0);
      xm(1'b1, 16'h0023, 8'h5A, 1'b0);
      xm(1'b0, 16'h0023, 8'h5A, 1'b0);
      xm(1'b1, 16'h02FF, 8'h3C, 1'b0);
      xm(1'b0, 16'h02FF, 8'h3C, 1'b0);
      xm(1'b1, 16'h0300, 8'h77, 1'b1);
      xm(1'b0, 16'h0300, 8'h00, 1'b1);
      xm(1'b0, 16'h0000, 8'h99, 1'b0);
      restart(SIZE_NONE, 1'b0);
      reg_op(1'b0, REG_SP, SP_RESET);
      fetch(1'b0, 16'h0000, 1'b0, 15'h0000);
      tally_and_finish();
   end
endmodule
